// File: include/fan_pwm_consts.svh
`ifndef FAN_PWM_CONSTS_SVH
`define FAN_PWM_CONSTS_SVH
`define DUTY_WIDTH       8
`define RAMP_TOP         8'hff
`define STARTUP_TICKS    6'h20
`define DIAG_TICKS       6'h03
`define MISS_TICKS       6'h20
`define TIMER_RESET      6'h00
`endif

// File: include/fan_pwm_pkg.sv
package fan_pwm_pkg;
	typedef enum logic [5:0] {
		ST_SHUTDOWN = 6'h01,
		ST_AUTOOFF  = 6'h02,
		ST_STARTUP  = 6'h04,
		ST_RUN      = 6'h08,
		ST_DIAG     = 6'h10,
		ST_LATCHED  = 6'h20
	} fan_state_t;
endpackage

// File: src/fan_pwm_startup_fault_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "fan_pwm_consts.svh"

module fan_pwm_startup_fault_ctrl #(
	parameter int DUTY_WIDTH = `DUTY_WIDTH
) (
	input  wire logic                  CORE_CLK,
	input  wire logic                  SYS_RST,
	input  wire logic [DUTY_WIDTH-1:0] DUTY_DEMAND,
	input  wire logic                  SHUTDOWN_LEVEL,
	input  wire logic                  RELEASE_LEVEL,
	input  wire logic                  AUTOOFF_BELOW,
	input  wire logic                  AUTOOFF_ABOVE_HYST,
	input  wire logic                  OVERTEMP_LEVEL,
	input  wire logic                  TACH_PULSE,
	output logic                       FAN_DRIVE_OUT,
	output logic                       FAULT_N_OUT,
	output logic                       FAULT_N_OE
);

	// Each comparator level crosses into this clock through its own pair of
	// flip-flops; only the second stage is read by any logic, so a level
	// that changes near the edge cannot reach two decoders with two values.
	logic shdn_a;
	logic shdn_s;
	logic aoff_a;
	logic aoff_s;
	logic aon_a;
	logic aon_s;
	logic otemp_a;
	logic otemp_s;
	logic tach_a;
	logic tach_s;
	logic tach_prev;

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			shdn_a <= 1'b0;
			shdn_s <= 1'b0;
		end else begin
			shdn_a <= SHUTDOWN_LEVEL;
			shdn_s <= shdn_a;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			aoff_a <= 1'b0;
			aoff_s <= 1'b0;
		end else begin
			aoff_a <= AUTOOFF_BELOW;
			aoff_s <= aoff_a;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			aon_a <= 1'b0;
			aon_s <= 1'b0;
		end else begin
			aon_a <= AUTOOFF_ABOVE_HYST;
			aon_s <= aon_a;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			otemp_a <= 1'b0;
			otemp_s <= 1'b0;
		end else begin
			otemp_a <= OVERTEMP_LEVEL;
			otemp_s <= otemp_a;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			tach_a    <= 1'b0;
			tach_s    <= 1'b0;
			tach_prev <= 1'b0;
		end else begin
			tach_a    <= TACH_PULSE;
			tach_s    <= tach_a;
			tach_prev <= tach_s;
		end
	end

	// The edge detector resets low, the idle level of the tach line, so no
	// false pulse follows reset.
	wire tach_edge = tach_s & ~tach_prev;

	// Release is only sampled while in shutdown, so it needs its own pair.
	logic rel_a;
	logic rel_s;

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			rel_a <= 1'b0;
			rel_s <= 1'b0;
		end else begin
			rel_a <= RELEASE_LEVEL;
			rel_s <= rel_a;
		end
	end

	// Ramp counter; the tick marks the start of each PWM period.
	// It wraps freely, so one period is two to the power DUTY_WIDTH clocks.
	logic [DUTY_WIDTH-1:0] ramp;
	wire                   tick = (ramp == {DUTY_WIDTH{1'b0}});

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			ramp <= {DUTY_WIDTH{1'b0}};
		end else begin
			ramp <= ramp + 1'b1;
		end
	end

	// The top demand code means 100%: the drive never drops within the period.
	wire full_duty = (DUTY_DEMAND == {DUTY_WIDTH{1'b1}});
	wire pwm_on    = full_duty | (ramp < DUTY_DEMAND);

	// State, the shared period timer, the one-retry flag and the tach-seen flag.
	fan_pwm_pkg::fan_state_t state;
	fan_pwm_pkg::fan_state_t next_state;
	logic [5:0]              timer;
	logic [5:0]              next_timer;
	logic                    retry;
	logic                    next_retry;
	logic                    seen;
	logic                    next_seen;

	wire in_shdn  = (state == fan_pwm_pkg::ST_SHUTDOWN);
	wire in_aoff  = (state == fan_pwm_pkg::ST_AUTOOFF);
	wire in_latch = (state == fan_pwm_pkg::ST_LATCHED);
	wire in_run   = (state == fan_pwm_pkg::ST_RUN);
	// A timer ends on the tick that would take it from one to zero.
	function automatic logic timer_hit(input logic step, input logic [5:0] value);
		return step && (value == 6'h01);
	endfunction

	// Each tick takes one PWM period off a running timer; zero means idle.
	function automatic logic [5:0] count_down(input logic step, input logic [5:0] value);
		logic [5:0] result;
		result = value;
		if (step && value != `TIMER_RESET) begin
			result = value - 6'h01;
		end
		return result;
	endfunction

	wire expired  = timer_hit(tick, timer);

	always_comb begin
		// Defaults: hold state, run the timer down, remember any tach edge.
		next_state = state;
		next_timer = count_down(tick, timer);
		next_retry = retry;
		next_seen  = seen | tach_edge;
		// Shutdown overrides every state and wipes timers and pending faults.
		if (shdn_s && !in_shdn) begin
			next_state = fan_pwm_pkg::ST_SHUTDOWN;
			next_timer = `TIMER_RESET;
			next_retry = 1'b0;
			next_seen  = 1'b0;
		end else begin
			case (state)
				// Everything is held off until the release level is seen.
				fan_pwm_pkg::ST_SHUTDOWN: begin
					if (rel_s && !shdn_s) begin
						next_state = fan_pwm_pkg::ST_AUTOOFF;
					end
				end
				// The fan stays off until the input clears the hysteresis band.
				fan_pwm_pkg::ST_AUTOOFF: begin
					if (aon_s) begin
						next_state = fan_pwm_pkg::ST_STARTUP;
						next_timer = `STARTUP_TICKS;
						next_retry = 1'b0;
						next_seen  = 1'b0;
					end
				end
				// The boost runs its full length; a tach edge only marks the fan alive.
				fan_pwm_pkg::ST_STARTUP: begin
					if (aoff_s) begin
						next_state = fan_pwm_pkg::ST_AUTOOFF;
					end else if (expired) begin
						if (seen) begin
							next_state = fan_pwm_pkg::ST_RUN;
							next_timer = `MISS_TICKS;
							next_seen  = 1'b0;
						end else if (retry) begin
							next_state = fan_pwm_pkg::ST_LATCHED;
						end else begin
							next_timer = `STARTUP_TICKS;
							next_retry = 1'b1;
						end
					end
				end
				// A tach edge outranks a timeout in the same cycle: the fan has turned.
				fan_pwm_pkg::ST_RUN: begin
					if (aoff_s) begin
						next_state = fan_pwm_pkg::ST_AUTOOFF;
					end else if (tach_edge) begin
						next_timer = `MISS_TICKS;
					end else if (expired) begin
						next_state = fan_pwm_pkg::ST_DIAG;
						next_timer = `DIAG_TICKS;
						next_seen  = 1'b0;
					end
				end
				// A single tach edge in the window returns the fan to normal running.
				fan_pwm_pkg::ST_DIAG: begin
					if (aoff_s) begin
						next_state = fan_pwm_pkg::ST_AUTOOFF;
					end else if (tach_edge) begin
						next_state = fan_pwm_pkg::ST_RUN;
						next_timer = `MISS_TICKS;
					end else if (expired) begin
						next_state = fan_pwm_pkg::ST_STARTUP;
						next_timer = `STARTUP_TICKS;
						next_retry = 1'b1;
						next_seen  = 1'b0;
					end
				end
				// Only the shutdown override above can leave this state.
				fan_pwm_pkg::ST_LATCHED: begin
					next_state = fan_pwm_pkg::ST_LATCHED;
				end
				default: begin
					next_state = fan_pwm_pkg::ST_SHUTDOWN;
				end
			endcase
		end
	end

	// Power-up comes up in auto-off so a demand above hysteresis starts the fan.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			state <= fan_pwm_pkg::ST_AUTOOFF;
			timer <= `TIMER_RESET;
			retry <= 1'b0;
			seen  <= 1'b0;
		end else begin
			state <= next_state;
			timer <= next_timer;
			retry <= next_retry;
			seen  <= next_seen;
		end
	end

	// Forced drive covers the start-up boost and the diagnostic window.
	wire drv_boost = (state == fan_pwm_pkg::ST_STARTUP);
	wire drv_diag  = (state == fan_pwm_pkg::ST_DIAG);
	wire drv_pwm   = in_run & pwm_on;
	wire next_drv  = drv_boost | drv_diag | drv_pwm;

	// Full demand warns without stopping the fan; the warning clears as soon
	// as demand drops. Shutdown and auto-off mask every fault source.
	wire flt_full  = in_run & full_duty;
	wire flt_otemp = in_run & otemp_s;
	wire flt_any   = in_latch | flt_full | flt_otemp;
	wire flt_mask  = in_shdn | in_aoff;
	wire next_flt  = flt_any & ~flt_mask;

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			FAN_DRIVE_OUT <= 1'b0;
			FAULT_N_OE    <= 1'b0;
		end else begin
			FAN_DRIVE_OUT <= next_drv;
			FAULT_N_OE    <= next_flt;
		end
	end

	// The fault pin is open drain: data is always low and the enable pulls the line.
	assign FAULT_N_OUT = 1'b0;

endmodule // fan_pwm_startup_fault_ctrl
`default_nettype wire

// File: test/fan_model.sv
`timescale 1ns/10ps
`default_nettype none
module fan_model (
	input  wire logic clk,
	input  wire logic drive,
	input  wire logic stall,
	input  wire logic oe,
	input  wire logic data,
	output wire logic tach,
	output wire logic line
);
	logic [7:0] phase = 8'h00;
	assign line = oe ? data : 1'b1;
	assign tach = phase[6];
	// The rotor commutates only while powered and free to turn.
	always @(posedge clk) begin
		if (drive && !stall) begin
			phase <= phase + 8'h01;
		end
	end
endmodule // fan_model
`default_nettype wire

// File: test/fan_pwm_chk.sv
`timescale 1ns/10ps
`default_nettype none
module fan_pwm_chk #(
	parameter int DUTY_WIDTH = 8
) (
	input wire logic                  CORE_CLK,
	input wire logic                  SYS_RST,
	input wire logic [DUTY_WIDTH-1:0] DUTY_DEMAND,
	input wire logic                  SHUTDOWN_LEVEL,
	input wire logic                  AUTOOFF_BELOW,
	input wire logic                  OVERTEMP_LEVEL,
	input wire logic                  FAN_DRIVE_OUT,
	input wire logic                  FAULT_N_OUT,
	input wire logic                  FAULT_N_OE
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	a_fault_data_low: assert property (FAULT_N_OUT == 1'b0) else $error("fault data high");
	a_reset_idle: assert property ($fell(SYS_RST) |-> !FAN_DRIVE_OUT && !FAULT_N_OE) else $error("busy");
	a_shdn_drive_off: assert property (SHUTDOWN_LEVEL [*6] |-> !FAN_DRIVE_OUT) else $error("drive on");
	a_shdn_fault_off: assert property (SHUTDOWN_LEVEL [*6] |-> !FAULT_N_OE) else $error("fault on");
	a_aoff_quiet: assert property ((AUTOOFF_BELOW && !FAULT_N_OE) [*6] |=> !FAN_DRIVE_OUT && !FAULT_N_OE)
		else $error("active in auto-off");
	a_full_fault: assert property ((&DUTY_DEMAND && FAN_DRIVE_OUT) [*8] |-> FAULT_N_OE)
		else $error("no full duty fault");
	a_fault_release: assert property ((!(&DUTY_DEMAND) && !OVERTEMP_LEVEL && FAN_DRIVE_OUT) [*8] |-> !FAULT_N_OE)
		else $error("fault kept");
	a_latch_hold: assert property ($rose(FAULT_N_OE) && !FAN_DRIVE_OUT && !OVERTEMP_LEVEL && !(&DUTY_DEMAND)
		|=> (FAULT_N_OE && !FAN_DRIVE_OUT) [*3]) else $error("latch lost");
endmodule // fan_pwm_chk
bind fan_pwm_startup_fault_ctrl fan_pwm_chk #(.DUTY_WIDTH(DUTY_WIDTH)) fan_pwm_chk_inst (.CORE_CLK, .SYS_RST,
	.DUTY_DEMAND, .SHUTDOWN_LEVEL, .AUTOOFF_BELOW, .OVERTEMP_LEVEL, .FAN_DRIVE_OUT, .FAULT_N_OUT, .FAULT_N_OE);
`default_nettype wire

// File: test/fan_pwm_startup_fault_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module fan_pwm_startup_fault_ctrl_tb;
	typedef struct packed {logic [7:0] d; logic o; logic [8:0] h; logic f;} row_t;
	row_t rows [5] = '{'{8'h00, 0, 0, 1}, '{8'h40, 0, 64, 1}, '{8'hff, 0, 256, 0},
		'{8'hc0, 0, 192, 1}, '{8'h40, 1, 64, 0}};
	logic clk = 0, rst = 1, shdn = 0, rel = 1, below = 0, hyst = 1, ot = 0, stall = 1;
	logic [7:0] duty = 8'h80;
	wire logic drive, oe, data, tach, line;
	int errors = 0, compares = 0, n, hi, run, top;
	always #4 clk = ~clk;
	fan_pwm_startup_fault_ctrl fan_pwm_startup_fault_ctrl_inst (.CORE_CLK(clk), .SYS_RST(rst), .DUTY_DEMAND(duty),
		.SHUTDOWN_LEVEL(shdn), .RELEASE_LEVEL(rel), .AUTOOFF_BELOW(below), .AUTOOFF_ABOVE_HYST(hyst),
		.OVERTEMP_LEVEL(ot), .TACH_PULSE(tach), .FAN_DRIVE_OUT(drive), .FAULT_N_OUT(data), .FAULT_N_OE(oe));
	fan_model fan_model_inst (.clk(clk), .drive(drive), .stall(stall), .oe(oe), .data(data), .tach(tach), .line(line));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %0t got %0h want %0h", $time, seen, exp);
		end
	endtask
	task automatic count(input int k);
		hi = 0;
		repeat (k) begin
			@(negedge clk);
			hi += int'(drive === 1'b1);
		end
	endtask
	task automatic wait_fault;
		n = 0;
		top = 0;
		run = 0;
		while (line !== 1'b0 && n < 23040) begin
			@(negedge clk);
			n++;
			run = (drive === 1'b1) ? run + 1 : 0;
			top = (run > top) ? run : top;
		end
	endtask
	task automatic results;
		if (errors == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		#800000;
		errors++;
		results;
	end
	initial begin
		count(6);
		rst = 0;
		count(1);
		check({drive, line}, 1);
		wait_fault;
		check(top >= 63 * 256 && n <= 64 * 256 + 16, 1);
		below = 1;
		count(600);
		check({drive, line}, 0);
		shdn = 1;
		rel = 0;
		below = 0;
		count(20);
		check({drive, line}, 1);
		shdn = 0;
		count(20);
		check({drive, line}, 1);
		rel = 1;
		stall = 0;
		count(34 * 256);
		check(hi >= 32 * 256, 1);
		foreach (rows[i]) begin
			duty = rows[i].d;
			ot = rows[i].o;
			count(300);
			count(256);
			check(hi >= rows[i].h && hi <= rows[i].h + 1, 1);
			check(line, rows[i].f);
		end
		below = 1;
		hyst = 0;
		count(20);
		check({drive, line}, 1);
		below = 0;
		count(600);
		check({drive, line}, 1);
		ot = 0;
		hyst = 1;
		count(30 * 256);
		check(drive, 1);
		count(3 * 256);
		stall = 1;
		wait_fault;
		check(top >= 34 * 256 && top <= 35 * 256 + 80, 1);
		check(n >= 64 * 256 && n <= 68 * 256, 1);
		results;
	end
endmodule // fan_pwm_startup_fault_ctrl_tb
`default_nettype wire
